// *** include/pcgpio_pkg.sv ***
// Constants and register map for the port C general-purpose I/O block
package pcgpio_pkg;

// ----------------------------------------------------------------------
// Port geometry
// ----------------------------------------------------------------------
localparam int PORT_WIDTH = 8;
localparam int NIB_WIDTH = 4;
localparam int ADDR_WIDTH = 4;

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
localparam logic [ADDR_WIDTH-1:0] OFF_PIN_DATA = 4'h0;
localparam logic [ADDR_WIDTH-1:0] OFF_DIRECTION = 4'h4;
localparam logic [ADDR_WIDTH-1:0] OFF_PULLDOWN_A = 4'h8;
localparam logic [ADDR_WIDTH-1:0] OFF_MASK_OPTION = 4'hc;

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
localparam int PDA_LOWER_BIT = 0;
localparam int PDA_UPPER_BIT = 1;
localparam int MOR_GPD_BIT = 0;

// ----------------------------------------------------------------------
// Reset values and fixed answers
// ----------------------------------------------------------------------
localparam logic [PORT_WIDTH-1:0] DIRECTION_RESET = 8'h00;
localparam logic [1:0] INHIBIT_RESET = 2'h0;
localparam logic MOR_GPD_RESET = 1'b0;
localparam logic [31:0] READ_ZERO = 32'h0000_0000;
localparam logic [1:0] RESP_OKAY = 2'h0;
localparam logic [1:0] RESP_DECODEERROR = 2'h3;

// ----------------------------------------------------------------------
// Bus slave states
// ----------------------------------------------------------------------
typedef enum logic [1:0] {
    PCG_IDLE = 2'b01,
    PCG_ANSWER = 2'b10
} pcg_state_t;

// Word-aligned byte address to one-hot select
function automatic logic addr_hit(input logic [ADDR_WIDTH-1:0] a,
                                  input logic [ADDR_WIDTH-1:0] off);
    return a == off;
endfunction : addr_hit

endpackage : pcgpio_pkg

// *** logic/pcg_port.sv ***
// Port C eight-pin bidirectional port with nibble pulldowns
module pcg_port
    import pcgpio_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [ADDR_WIDTH-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic [1:0] avs_response,
    output logic avs_waitrequest,
    // Port pins
    input wire logic [PORT_WIDTH-1:0] pin_in,
    output logic [PORT_WIDTH-1:0] pin_out,
    output logic [PORT_WIDTH-1:0] pin_oe,
    output logic [PORT_WIDTH-1:0] pulldown_en
);

// ----------------------------------------------------------------------
// State
// ----------------------------------------------------------------------
logic [PORT_WIDTH-1:0] data_latch_reg;
logic [PORT_WIDTH-1:0] direction_reg;
logic upper_inhibit_reg;
logic lower_inhibit_reg;
logic global_pd_disable_reg;
logic [31:0] readdata_reg;
logic [1:0] response_reg;
pcg_state_t state_reg;
pcg_state_t state_next;
logic [PORT_WIDTH-1:0] pin_sync;

// ----------------------------------------------------------------------
// Pin synchroniser
// ----------------------------------------------------------------------
pcg_sync #(
    .WIDTH(PORT_WIDTH)
) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in(pin_in),
    .sync_out(pin_sync)
);

// ----------------------------------------------------------------------
// Bus decode
// ----------------------------------------------------------------------
wire req = (avs_read || avs_write) && (state_reg == PCG_IDLE);
wire lane0 = avs_byteenable[0];
wire hit_data = addr_hit(avs_address, OFF_PIN_DATA);
wire hit_dir = addr_hit(avs_address, OFF_DIRECTION);
wire hit_pda = addr_hit(avs_address, OFF_PULLDOWN_A);
wire hit_mor = addr_hit(avs_address, OFF_MASK_OPTION);
wire hit_any = hit_data || hit_dir || hit_pda || hit_mor;
// Writes land only at the edge where waitrequest is low
wire wr = avs_write && lane0 && (state_reg == PCG_ANSWER);
wire wr_data = wr && hit_data;
wire wr_dir = wr && hit_dir;
wire wr_pda = wr && hit_pda;
wire wr_mor = wr && hit_mor;

// Mixed read: latch for outputs, synced pin for inputs
wire [PORT_WIDTH-1:0] data_view =
    (direction_reg & data_latch_reg) |
    (~direction_reg & pin_sync);

wire [31:0] read_mux =
    hit_data ? {24'h000000, data_view} :
    hit_dir ? {24'h000000, direction_reg} :
    hit_mor ? {31'h00000000, global_pd_disable_reg} :
    READ_ZERO;

// ----------------------------------------------------------------------
// Handshake state machine
// ----------------------------------------------------------------------
always_comb begin
    state_next = state_reg;
    unique case (state_reg)
        PCG_IDLE: begin
            if (avs_read || avs_write) begin
                state_next = PCG_ANSWER;
            end
        end
        PCG_ANSWER: begin
            state_next = PCG_IDLE;
        end
        default: begin
            state_next = PCG_IDLE;
        end
    endcase
end

assign avs_waitrequest = (avs_read || avs_write) && (state_reg != PCG_ANSWER);

always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
        state_reg <= PCG_IDLE;
    end else begin
        state_reg <= state_next;
    end
end

// ----------------------------------------------------------------------
// Read data register
// ----------------------------------------------------------------------
always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
        readdata_reg <= READ_ZERO;
        response_reg <= RESP_OKAY;
    end else if (req) begin
        readdata_reg <= avs_read ? read_mux : READ_ZERO;
        response_reg <= hit_any ? RESP_OKAY : RESP_DECODEERROR;
    end
end

assign avs_readdata = readdata_reg;
assign avs_response = response_reg;

// ----------------------------------------------------------------------
// Data latch: not reset
// ----------------------------------------------------------------------
always_ff @(posedge sys_clk) begin
    if (wr_data) begin
        data_latch_reg <= avs_writedata[PORT_WIDTH-1:0];
    end
end

// ----------------------------------------------------------------------
// Direction and pulldown control
// ----------------------------------------------------------------------
always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
        direction_reg <= DIRECTION_RESET;
    end else if (wr_dir) begin
        direction_reg <= avs_writedata[PORT_WIDTH-1:0];
    end
end

always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
        upper_inhibit_reg <= INHIBIT_RESET[1];
        lower_inhibit_reg <= INHIBIT_RESET[0];
    end else if (wr_pda) begin
        upper_inhibit_reg <= avs_writedata[PDA_UPPER_BIT];
        lower_inhibit_reg <= avs_writedata[PDA_LOWER_BIT];
    end
end

// Mask option bit survives reset so reset never re-enables pulldowns that it has disabled
always_ff @(posedge sys_clk) begin
    if (wr_mor) begin
        global_pd_disable_reg <= avs_writedata[MOR_GPD_BIT];
    end
end

// ----------------------------------------------------------------------
// Pin drive
// ----------------------------------------------------------------------
wire [PORT_WIDTH-1:0] inhibit_vec =
    {{NIB_WIDTH{upper_inhibit_reg}}, {NIB_WIDTH{lower_inhibit_reg}}};

assign pin_oe = direction_reg;
assign pin_out = data_latch_reg;
assign pulldown_en = ~direction_reg & ~inhibit_vec &
    {PORT_WIDTH{~global_pd_disable_reg}};

endmodule : pcg_port

// *** logic/pcg_sync.sv ***
// Two-flop synchroniser bank for the port pins
module pcg_sync
    import pcgpio_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

logic [WIDTH-1:0] meta_reg;
logic [WIDTH-1:0] sync_reg;

always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
        meta_reg <= '0;
        sync_reg <= '0;
    end else begin
        meta_reg <= async_in;
        sync_reg <= meta_reg;
    end
end

assign sync_out = sync_reg;

endmodule : pcg_sync

// *** sim/pcg_pin_model.sv ***
// Behavioural model of the circuitry on the port pins
module pcg_pin_model
    import pcgpio_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Device side
    input wire logic [PORT_WIDTH-1:0] pin_out,
    input wire logic [PORT_WIDTH-1:0] pin_oe,
    input wire logic [PORT_WIDTH-1:0] pulldown_en,
    // Outside drivers
    input wire logic [PORT_WIDTH-1:0] ext_en,
    input wire logic [PORT_WIDTH-1:0] ext_val,
    output logic [PORT_WIDTH-1:0] level
);
timeunit 1ns;
timeprecision 1ns;
logic [PORT_WIDTH-1:0] tog = 8'h00;
always @(posedge sys_clk) tog <= ~tog;
// Floating pins toggle; pulled pins read low
assign level = pin_oe & pin_out | ~pin_oe & ext_en & ext_val
    | ~pin_oe & ~ext_en & ~pulldown_en & tog;
endmodule : pcg_pin_model

// *** sim/pcg_port_props.sv ***
// Assertion checker for the port C GPIO block
module pcg_port_props
    import pcgpio_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register bus
    input wire logic [ADDR_WIDTH-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic [1:0] avs_response,
    input wire logic avs_waitrequest,
    // Pins
    input wire logic [PORT_WIDTH-1:0] pin_in,
    input wire logic [PORT_WIDTH-1:0] pin_out,
    input wire logic [PORT_WIDTH-1:0] pin_oe,
    input wire logic [PORT_WIDTH-1:0] pulldown_en
);
default clocking @(posedge sys_clk);
endclocking
default disable iff (!reset_n);
wire wtk = avs_write && !avs_waitrequest && avs_byteenable[0];
wire rdd = avs_read && !avs_waitrequest && avs_address == OFF_PIN_DATA;
wire [7:0] wd8 = avs_writedata[7:0];
logic [1:0] inh;
logic gpd;
logic known = 1'b0;
wire [7:0] pd_exp = gpd ? 8'h00 : ~pin_oe & {{4{~inh[1]}}, {4{~inh[0]}}};
// Shadow of the pulldown controls: the write-only inhibit bits and the readable mask option bit
always_ff @(posedge sys_clk) begin
    if (!reset_n)
        inh <= INHIBIT_RESET;
    else if (wtk && avs_address == OFF_PULLDOWN_A)
        inh <= wd8[1:0];
end
always_ff @(posedge sys_clk) begin
    if (wtk && avs_address == OFF_MASK_OPTION) begin
        gpd <= wd8[MOR_GPD_BIT];
        known <= 1'b1;
    end
end
sequence s_pins_steady;
    $stable(pin_in)[*5];
endsequence
a_oe_reset: assert property (disable iff (1'b0) !reset_n |=> pin_oe == 8'h00)
    else $error("direction not cleared by reset");
a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait state");
a_dir_write: assert property (
    wtk && avs_address == OFF_DIRECTION |=> pin_oe == $past(wd8))
    else $error("direction write lost");
a_data_write: assert property (
    wtk && avs_address == OFF_PIN_DATA |=> pin_out == $past(wd8))
    else $error("data write lost");
a_read_latch: assert property (
    rdd |-> (avs_readdata[7:0] & pin_oe) == (pin_out & pin_oe))
    else $error("output bit not read from latch");
a_read_pin: assert property (s_pins_steady ##0 rdd |->
    ((avs_readdata[7:0] ^ pin_in) & ~pin_oe) == 8'h00)
    else $error("input bit not read from pin");
a_pd_map: assert property (disable iff (1'b0)
    known |-> pulldown_en == pd_exp)
    else $error("pulldown enables wrong");
a_resp_map: assert property (
    (avs_read || avs_write) && !avs_waitrequest |-> avs_response ==
    (avs_address[1:0] == 2'h0 ? RESP_OKAY : RESP_DECODEERROR))
    else $error("bus response wrong");
endmodule : pcg_port_props
bind pcg_port pcg_port_props i_props (.*);

// *** sim/pcg_port_tb.sv ***
// Self-checking testbench for the port C GPIO block
module pcg_port_tb
    import pcgpio_pkg::*;
;
timeunit 1ns;
timeprecision 1ns;
logic sys_clk = 1'b0;
logic reset_n = 1'b0;
logic [3:0] avs_address = 4'h0;
logic avs_read = 1'b0;
logic avs_write = 1'b0;
logic [31:0] avs_writedata = 32'h0;
logic [3:0] avs_byteenable = 4'hf;
logic [7:0] ext_en = 8'h00;
logic [7:0] ext_val = 8'h00;
logic [31:0] avs_readdata;
logic [1:0] avs_response;
logic avs_waitrequest;
logic [7:0] pin_in, pin_out, pin_oe, pulldown_en, q;
logic [1:0] qr;
int bad_count = 0;
int total_checks = 0;
int cyc = 0;
always #5 sys_clk = ~sys_clk;
pcg_port i_dut (.*);
pcg_pin_model i_pins (.*, .level(pin_in));
task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
        bad_count++;
        $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
endtask : chk
task automatic bus(logic w, logic [3:0] a, logic [7:0] d);
    logic ok;
    ok = 1'b0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    while (!ok) begin
        @(posedge sys_clk);
        ok = (avs_waitrequest === 1'b0);
    end
    q = avs_readdata[7:0];
    qr = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Let the accepted write settle before outputs are compared
    @(posedge sys_clk);
endtask : bus
task automatic rst();
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
endtask : rst
task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask : wrap_up
always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
        bad_count++;
        wrap_up();
    end
end
initial begin
    rst();
    bus(1, OFF_MASK_OPTION, 8'h00);
    chk("oe", pin_oe, 8'h00);
    chk("pulldown", pulldown_en, 8'hff);
    $display("reset test done");
    bus(1, OFF_PIN_DATA, 8'ha5);
    ext_en <= 8'hff;
    ext_val <= 8'h3c;
    repeat (4) @(posedge sys_clk);
    bus(0, OFF_PIN_DATA, 8'h00);
    chk("pins", q, 8'h3c);
    chk("latch", pin_out, 8'ha5);
    ext_en <= 8'h0f;
    bus(1, OFF_DIRECTION, 8'hf0);
    bus(0, OFF_PIN_DATA, 8'h00);
    chk("mixed", q, 8'hac);
    bus(0, OFF_DIRECTION, 8'h00);
    chk("dir", q, 8'hf0);
    chk("out", pin_out & pin_oe, 8'ha0);
    chk("pulldown", pulldown_en, 8'h0f);
    chk("ganged", {7'h00, pin_in[7] ^ pin_in[5]}, 8'h00);
    $display("data test done");
    ext_en <= 8'h00;
    bus(1, OFF_PULLDOWN_A, 8'h00);
    bus(1, OFF_DIRECTION, 8'h00);
    repeat (4) @(posedge sys_clk);
    bus(0, OFF_PIN_DATA, 8'h00);
    chk("pulled", q, 8'h00);
    for (int i = 0; i < 4; i++) begin
        bus(1, OFF_PULLDOWN_A, 8'(i));
        chk("pd", pulldown_en, {{4{i[1] == 0}}, {4{i[0] == 0}}});
    end
    bus(1, OFF_MASK_OPTION, 8'h01);
    bus(1, OFF_PULLDOWN_A, 8'h00);
    chk("pulldown", pulldown_en, 8'h00);
    bus(1, OFF_PULLDOWN_A, 8'h03);
    rst();
    chk("pulldown", pulldown_en, 8'h00);
    chk("latch", pin_out, 8'ha5);
    bus(1, OFF_MASK_OPTION, 8'h00);
    chk("pulldown", pulldown_en, 8'hff);
    $display("pulldown test done");
    bus(0, 4'h2, 8'h00);
    chk("resp", {6'h0, qr}, {6'h0, RESP_DECODEERROR});
    chk("unmapped", q, 8'h00);
    avs_byteenable <= 4'he;
    bus(1, OFF_DIRECTION, 8'hff);
    avs_byteenable <= 4'hf;
    bus(0, OFF_DIRECTION, 8'h00);
    chk("lane", q, 8'h00);
    $display("bus test done");
    wrap_up();
end
endmodule : pcg_port_tb
